// ==== hw/als_regs_pkg.sv ====
package als_regs_pkg;

  // ----------------------------------------------------------------
  // Register pointers
  // ----------------------------------------------------------------
  localparam logic [7:0] PTR_LIGHT_RESULT = 8'h00;
  localparam logic [7:0] PTR_OPERATING_CONFIG = 8'h01;
  localparam logic [7:0] PTR_LOWER_THRESHOLD = 8'h02;
  localparam logic [7:0] PTR_UPPER_THRESHOLD = 8'h03;
  localparam logic [7:0] PTR_MAKER_CODE_WORD = 8'h7E;
  localparam logic [7:0] PTR_PART_CODE_WORD = 8'h7F;

  // ----------------------------------------------------------------
  // Field values and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] RANGE_AUTO = 4'hC;
  localparam logic [15:0] LIGHT_RESULT_RESET = 16'h0000;
  localparam logic [15:0] OPERATING_CONFIG_RESET = 16'hC810;
  localparam logic [15:0] UNMAPPED_READ_VALUE = 16'h0000;
  localparam logic [2:0] LAST_BIT_INDEX = 3'h7;

  // ----------------------------------------------------------------
  // Word layouts, most significant field first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] exponent;
    logic [11:0] mantissa;
  } result_word_type;

  typedef struct packed {
    logic [3:0] range_select;
    logic conversion_time;
    logic [1:0] mode;
    logic overflow_flag;
    logic conversion_ready_flag;
    logic above_high_threshold_hit;
    logic below_low_threshold_hit;
    logic latch;
    logic irq_active_sense;
    logic exponent_mask;
    logic [1:0] fault_count;
  } config_word_type;

  // Status levels coming from the conversion engine
  typedef struct packed {
    logic overflow_flag;
    logic conversion_ready_flag;
    logic above_high_threshold_hit;
    logic below_low_threshold_hit;
  } conv_flags_type;

  // ----------------------------------------------------------------
  // Serial slave states
  // ----------------------------------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_ADDR      = 9'h002,
    ST_ACK_ADDR  = 9'h004,
    ST_PTR       = 9'h008,
    ST_ACK_PTR   = 9'h010,
    ST_WDATA     = 9'h020,
    ST_ACK_WDATA = 9'h040,
    ST_RDATA     = 9'h080,
    ST_RACK      = 9'h100
  } slave_state_type;

endpackage : als_regs_pkg

// ==== hw/ambient_light_register_map.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Every register is sixteen bits wide as the host sees it.
// - Pointers 00h..03h select result, config, lower and upper threshold.
// - Pointers 7Eh and 7Fh return the maker and part code words.
// - Result word always holds the latest completed conversion output.
// - Result word: exponent in bits 15:12, mantissa in bits 11:0.
// - Result word is read-only; exponent and mantissa reset to zero.
// - Mantissa is unsigned binary, zero dark, all ones full scale.
// - Exponent codes 0..11 pick binary-weighted ranges from 0.02 lux step.
// - Exponent mask with manual range below 1100b reads exponent zero.
// - Config word field order from range select down to fault count.
// - Registers reached only over serial bus, addressed then pointer.
// - Words travel as two bytes, most significant byte first.
// - Pointer is kept until the host writes a new one.
// - Range 1100b is automatic; engine exponent reported; 1101b+ reserved.
// - Config write aborts running conversion; new one starts if asked.
module ambient_light_register_map #(
  parameter logic [15:0] LOWER_THRESHOLD_RESET = 16'h0000,
  parameter logic [15:0] UPPER_THRESHOLD_RESET = 16'h0000,
  parameter logic [15:0] MAKER_CODE = 16'h1234, // Arbitrary value
  parameter logic [15:0] PART_CODE = 16'h5678 // Arbitrary value
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Serial bus, open drain data
  input wire logic [6:0] sensor_addr_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Conversion engine side
  input wire logic conv_done_i,
  input wire als_regs_pkg::result_word_type conv_result_i,
  input wire als_regs_pkg::conv_flags_type conv_flags_i,
  output als_regs_pkg::config_word_type config_o,
  output logic [15:0] lower_threshold_o,
  output logic [15:0] upper_threshold_o,
  output als_regs_pkg::result_word_type light_result_o,
  output logic conv_abort_o
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    als_regs_pkg::slave_state_type state;
    logic scl_prev;
    logic sda_prev;
    logic [2:0] bit_cnt;
    logic byte_done;
    logic [7:0] shift;
    logic [7:0] tx;
    logic rd_not_wr;
    logic lsb_sel;
    logic host_nack;
    logic sda_oe;
    logic [7:0] pointer;
    logic [7:0] wr_msb;
    als_regs_pkg::result_word_type result;
    als_regs_pkg::config_word_type cfg;
    logic [15:0] lower;
    logic [15:0] upper;
    logic cfg_written;
  } map_state_type;

  localparam map_state_type RESET_STATE = '{
    state: als_regs_pkg::ST_IDLE,
    scl_prev: 1'b1,
    sda_prev: 1'b1,
    bit_cnt: 3'h0,
    byte_done: 1'b0,
    shift: 8'h00,
    tx: 8'h00,
    rd_not_wr: 1'b0,
    lsb_sel: 1'b0,
    host_nack: 1'b0,
    sda_oe: 1'b0,
    pointer: als_regs_pkg::PTR_LIGHT_RESULT,
    wr_msb: 8'h00,
    result: als_regs_pkg::LIGHT_RESULT_RESET,
    cfg: als_regs_pkg::OPERATING_CONFIG_RESET,
    lower: LOWER_THRESHOLD_RESET,
    upper: UPPER_THRESHOLD_RESET,
    cfg_written: 1'b0
  };

  map_state_type s_reg;
  map_state_type s_next;
  als_regs_pkg::result_word_type result_view;
  als_regs_pkg::config_word_type config_view;
  logic [15:0] read_word;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic wr_commit;

  // ----------------------------------------------------------------
  // Read view of the addressed register
  // ----------------------------------------------------------------
  // Flags read back live from the engine; written flag bits are kept in cfg for config_o
  always_comb begin
    result_view = s_reg.result;
    if (s_reg.cfg.exponent_mask &&
        s_reg.cfg.range_select < als_regs_pkg::RANGE_AUTO) begin
      result_view.exponent = 4'h0;
    end
    config_view = s_reg.cfg;
    config_view.overflow_flag = conv_flags_i.overflow_flag;
    config_view.conversion_ready_flag = conv_flags_i.conversion_ready_flag;
    config_view.above_high_threshold_hit =
      conv_flags_i.above_high_threshold_hit;
    config_view.below_low_threshold_hit = conv_flags_i.below_low_threshold_hit;
    case (s_reg.pointer)
      als_regs_pkg::PTR_LIGHT_RESULT: read_word = result_view;
      als_regs_pkg::PTR_OPERATING_CONFIG: read_word = config_view;
      als_regs_pkg::PTR_LOWER_THRESHOLD: read_word = s_reg.lower;
      als_regs_pkg::PTR_UPPER_THRESHOLD: read_word = s_reg.upper;
      als_regs_pkg::PTR_MAKER_CODE_WORD: read_word = MAKER_CODE;
      als_regs_pkg::PTR_PART_CODE_WORD: read_word = PART_CODE;
      default: read_word = als_regs_pkg::UNMAPPED_READ_VALUE;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus event detection
  // ----------------------------------------------------------------
  // Pins are already synchronous, so one stored copy suffices
  assign scl_rise = scl_i & ~s_reg.scl_prev;
  assign scl_fall = ~scl_i & s_reg.scl_prev;
  assign bus_start = s_reg.scl_prev & scl_i & s_reg.sda_prev & ~sda_i;
  assign bus_stop = s_reg.scl_prev & scl_i & ~s_reg.sda_prev & sda_i;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    wr_commit = 1'b0;
    s_next.scl_prev = scl_i;
    s_next.sda_prev = sda_i;
    s_next.cfg_written = 1'b0;
    // Latest conversion overwrites, host cannot touch it
    if (conv_done_i) begin
      s_next.result = conv_result_i;
    end
    if (bus_stop) begin
      s_next.state = als_regs_pkg::ST_IDLE;
      s_next.sda_oe = 1'b0;
    end else if (bus_start) begin
      s_next.state = als_regs_pkg::ST_ADDR;
      s_next.bit_cnt = 3'h0;
      s_next.byte_done = 1'b0;
      s_next.sda_oe = 1'b0;
    end else if (scl_rise) begin
      // Sample on the rising clock edge
      case (s_reg.state)
        als_regs_pkg::ST_ADDR, als_regs_pkg::ST_PTR,
        als_regs_pkg::ST_WDATA: begin
          s_next.shift = {s_reg.shift[6:0], sda_i};
          s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
          s_next.byte_done = (s_reg.bit_cnt == als_regs_pkg::LAST_BIT_INDEX);
        end
        als_regs_pkg::ST_RDATA: begin
          s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
          s_next.byte_done = (s_reg.bit_cnt == als_regs_pkg::LAST_BIT_INDEX);
        end
        als_regs_pkg::ST_RACK: begin
          s_next.host_nack = sda_i;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      // Change the data line only while the clock is low
      case (s_reg.state)
        als_regs_pkg::ST_ADDR: begin
          if (s_reg.byte_done) begin
            s_next.byte_done = 1'b0;
            if (s_reg.shift[7:1] == sensor_addr_i) begin
              s_next.state = als_regs_pkg::ST_ACK_ADDR;
              s_next.sda_oe = 1'b1;
              s_next.rd_not_wr = s_reg.shift[0];
            end else begin
              s_next.state = als_regs_pkg::ST_IDLE;
            end
          end
        end
        als_regs_pkg::ST_ACK_ADDR: begin
          s_next.lsb_sel = 1'b0;
          s_next.bit_cnt = 3'h0;
          if (s_reg.rd_not_wr) begin
            s_next.state = als_regs_pkg::ST_RDATA;
            s_next.tx = read_word[15:8];
            s_next.sda_oe = ~read_word[15];
          end else begin
            s_next.state = als_regs_pkg::ST_PTR;
            s_next.sda_oe = 1'b0;
          end
        end
        als_regs_pkg::ST_PTR: begin
          if (s_reg.byte_done) begin
            s_next.byte_done = 1'b0;
            s_next.pointer = s_reg.shift;
            s_next.state = als_regs_pkg::ST_ACK_PTR;
            s_next.sda_oe = 1'b1;
          end
        end
        als_regs_pkg::ST_ACK_PTR: begin
          s_next.sda_oe = 1'b0;
          s_next.state = als_regs_pkg::ST_WDATA;
          s_next.lsb_sel = 1'b0;
          s_next.bit_cnt = 3'h0;
        end
        als_regs_pkg::ST_WDATA: begin
          if (s_reg.byte_done) begin
            s_next.byte_done = 1'b0;
            s_next.sda_oe = 1'b1;
            s_next.state = als_regs_pkg::ST_ACK_WDATA;
            if (!s_reg.lsb_sel) begin
              s_next.wr_msb = s_reg.shift;
            end else begin
              wr_commit = 1'b1;
              // Read-only and unmapped targets fall to default
              case (s_reg.pointer)
                als_regs_pkg::PTR_OPERATING_CONFIG: begin
                  s_next.cfg = {s_reg.wr_msb, s_reg.shift};
                  s_next.cfg_written = 1'b1;
                end
                als_regs_pkg::PTR_LOWER_THRESHOLD: begin
                  s_next.lower = {s_reg.wr_msb, s_reg.shift};
                end
                als_regs_pkg::PTR_UPPER_THRESHOLD: begin
                  s_next.upper = {s_reg.wr_msb, s_reg.shift};
                end
                default: begin
                end
              endcase
            end
          end
        end
        als_regs_pkg::ST_ACK_WDATA: begin
          s_next.sda_oe = 1'b0;
          s_next.lsb_sel = ~s_reg.lsb_sel;
          s_next.state = als_regs_pkg::ST_WDATA;
          s_next.bit_cnt = 3'h0;
        end
        als_regs_pkg::ST_RDATA: begin
          if (s_reg.byte_done) begin
            s_next.byte_done = 1'b0;
            s_next.sda_oe = 1'b0;
            s_next.state = als_regs_pkg::ST_RACK;
          end else begin
            s_next.tx = {s_reg.tx[6:0], 1'b0};
            s_next.sda_oe = ~s_reg.tx[6];
          end
        end
        als_regs_pkg::ST_RACK: begin
          // A nack parks the slave in idle until the next start
          if (s_reg.host_nack) begin
            s_next.state = als_regs_pkg::ST_IDLE;
          end else begin
            s_next.lsb_sel = ~s_reg.lsb_sel;
            s_next.tx = s_reg.lsb_sel ? read_word[15:8] : read_word[7:0];
            s_next.sda_oe = s_reg.lsb_sel ? ~read_word[15] : ~read_word[7];
            s_next.bit_cnt = 3'h0;
            s_next.state = als_regs_pkg::ST_RDATA;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_reg <= RESET_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state record, except sda_o tied low
  assign sda_o = 1'b0;
  assign sda_oe_o = s_reg.sda_oe;
  assign config_o = s_reg.cfg;
  assign lower_threshold_o = s_reg.lower;
  assign upper_threshold_o = s_reg.upper;
  assign light_result_o = s_reg.result;
  assign conv_abort_o = s_reg.cfg_written;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  AST_RESULT_LATEST: assert property (
    conv_done_i |=> light_result_o == $past(conv_result_i))
    else $error("result word missed a completed conversion");
  AST_RESULT_HOST_PROOF: assert property (
    !conv_done_i |=> $stable(light_result_o))
    else $error("result word changed without a conversion");
  AST_MASKED_EXPONENT: assert property (
    (s_reg.pointer == als_regs_pkg::PTR_LIGHT_RESULT &&
     s_reg.cfg.exponent_mask &&
     s_reg.cfg.range_select < als_regs_pkg::RANGE_AUTO)
    |-> read_word == {4'h0, s_reg.result.mantissa})
    else $error("masked exponent not reported as zero");
  AST_AUTO_EXPONENT: assert property (
    (s_reg.pointer == als_regs_pkg::PTR_LIGHT_RESULT &&
     s_reg.cfg.range_select == als_regs_pkg::RANGE_AUTO)
    |-> read_word == s_reg.result)
    else $error("automatic range exponent not reported");
  AST_UNMAPPED_FIXED: assert property (
    (s_reg.pointer > als_regs_pkg::PTR_UPPER_THRESHOLD &&
     s_reg.pointer < als_regs_pkg::PTR_MAKER_CODE_WORD)
    |-> read_word == als_regs_pkg::UNMAPPED_READ_VALUE)
    else $error("unmapped pointer read not fixed");
  AST_POINTER_HELD: assert property (
    !$stable(s_reg.pointer) |-> $past(s_reg.state) == als_regs_pkg::ST_PTR)
    else $error("pointer changed outside a pointer byte");
  AST_CONFIG_ABORT: assert property (
    (wr_commit && s_reg.pointer == als_regs_pkg::PTR_OPERATING_CONFIG)
    |=> conv_abort_o ##1 !conv_abort_o)
    else $error("config write did not pulse abort");
  AST_MSB_FIRST: assert property (
    (s_reg.state == als_regs_pkg::ST_ACK_ADDR && scl_fall && !bus_stop &&
     !bus_start && s_reg.rd_not_wr)
    |=> s_reg.tx == $past(read_word[15:8]))
    else $error("read did not start with the high byte");
  AST_ADDR_ACK: assert property (
    s_reg.state == als_regs_pkg::ST_ACK_ADDR |-> sda_oe_o)
    else $error("address acknowledge not driven low");

  COV_CONFIG_WRITE: cover property (
    wr_commit && s_reg.pointer == als_regs_pkg::PTR_OPERATING_CONFIG);
  COV_RESULT_READ: cover property (
    s_reg.state == als_regs_pkg::ST_RACK &&
    s_reg.pointer == als_regs_pkg::PTR_LIGHT_RESULT && s_reg.lsb_sel);
  COV_CONVERSION: cover property (conv_done_i);
  COV_HOST_NACK: cover property (
    s_reg.state == als_regs_pkg::ST_RACK && s_reg.host_nack && scl_fall);

endmodule : ambient_light_register_map

// ==== verification/als_host_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bus host model: open drain, it only ever pulls data low
// ----------------------------------------------------------------
module als_host_model (
  // Clock
  input wire logic core_clk_i,
  // Resolved data line
  input wire logic sda_i,
  // Host pin drives
  output logic scl_o,
  output logic sda_low_o,
  // Words read back
  output logic rd_valid_o,
  output logic [15:0] rd_word_o
);
  // Idle bus is released high
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    rd_valid_o = 1'b0;
    rd_word_o = 16'h0000;
  end

  // Three core cycles per step keeps every clock phase legal
  task automatic gap();
    repeat (3) @(negedge core_clk_i);
  endtask : gap

  // Data moves only while the clock is low
  task automatic clock_bit(input logic b, output logic s);
    sda_low_o = ~b;
    gap();
    scl_o = 1'b1;
    gap();
    s = sda_i;
    scl_o = 1'b0;
    gap();
  endtask : clock_bit

  // Start and stop are the only data edges with the clock high
  task automatic start_cond();
    sda_low_o = 1'b0;
    scl_o = 1'b1;
    gap();
    sda_low_o = 1'b1;
    gap();
    scl_o = 1'b0;
    gap();
  endtask : start_cond

  task automatic stop_cond();
    sda_low_o = 1'b1;
    gap();
    scl_o = 1'b1;
    gap();
    sda_low_o = 1'b0;
    gap();
  endtask : stop_cond

  // Eight bits, most significant first, then the ninth ack bit
  task automatic byte_io(input logic [7:0] tx, input logic ack_bit,
                         output logic [7:0] rx, output logic ack_line);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(tx[i], s);
      rx[i] = s;
    end
    clock_bit(ack_bit, ack_line);
  endtask : byte_io

  // Sends n bytes from the top of b; acks gives the device answers
  task automatic wr(input logic [31:0] b, input int n,
                    output logic [3:0] acks);
    logic [7:0] rx;
    logic s;
    acks = 4'h0;
    start_cond();
    for (int k = 0; k < n; k++) begin
      byte_io(b[31-8*k -: 8], 1'b1, rx, s);
      acks[k] = ~s;
    end
    stop_cond();
  endtask : wr

  // Reads n words, high byte then low byte; nack ends the last one
  task automatic rd(input logic [7:0] a, input int n, output logic ack);
    logic [7:0] hi;
    logic [7:0] lo;
    logic s;
    start_cond();
    byte_io(a, 1'b1, hi, s);
    ack = ~s;
    for (int j = 0; j < n; j++) begin
      byte_io(8'hFF, 1'b0, hi, s);
      byte_io(8'hFF, (j == n - 1), lo, s);
      rd_word_o = {hi, lo};
      rd_valid_o = 1'b1;
      @(negedge core_clk_i);
      rd_valid_o = 1'b0;
    end
    stop_cond();
  endtask : rd
endmodule : als_host_model

// ==== verification/ambient_light_register_map_test.sv ====
`timescale 1ns/1ps
module ambient_light_register_map_test;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [6:0] addr = 7'h44;
  logic scl, sda_low, sda_w, rd_valid, sda_o, sda_oe, abort;
  logic [15:0] rd_word, lo_thr, hi_thr;
  logic conv_done = 1'b0;
  als_regs_pkg::result_word_type conv_res = 16'h0000;
  als_regs_pkg::result_word_type res;
  als_regs_pkg::conv_flags_type flags = 4'h0;
  als_regs_pkg::config_word_type cfg;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h40BB;
  int n_fail = 0;
  int tests_run = 0;
  int aborts = 0;
  logic [7:0] ptrs [4] = '{8'h00, 8'h7E, 8'h7F, 8'h40};
  logic [3:0] ranges [4] = '{4'h5, 4'hC, 4'hD, 4'h0};
  logic masks [4] = '{1'b1, 1'b1, 1'b1, 1'b0};

  // Clock and open-drain data wire with pull-up
  always #12.5 core_clk_i = ~core_clk_i;
  assign sda_w = ~(sda_low | (sda_oe & ~sda_o));

  ambient_light_register_map uut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .sensor_addr_i(addr),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .conv_done_i(conv_done), .conv_result_i(conv_res),
    .conv_flags_i(flags), .config_o(cfg), .lower_threshold_o(lo_thr),
    .upper_threshold_o(hi_thr), .light_result_o(res),
    .conv_abort_o(abort)
  );

  als_host_model host (
    .core_clk_i(core_clk_i), .sda_i(sda_w), .scl_o(scl),
    .sda_low_o(sda_low), .rd_valid_o(rd_valid), .rd_word_o(rd_word)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Flag bits read back live from the engine
  function automatic logic [15:0] cfg_rd(input logic [15:0] w);
    return {w[15:9], flags, w[4:0]};
  endfunction : cfg_rd

  task automatic check16(input string name, input logic [15:0] e,
                         input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask : check16

  task automatic reg_wr(input logic [7:0] ptr, input logic [15:0] d);
    logic [3:0] acks;
    host.wr({addr, 1'b0, ptr, d}, 4, acks);
    check16("write acks", 16'h000F, {12'h000, acks});
  endtask : reg_wr

  // Pointer write alone, then n words read without a new pointer
  task automatic reg_rd(input logic [7:0] ptr, input logic [15:0] e,
                        input int n);
    logic [3:0] acks;
    logic a;
    host.wr({addr, 1'b0, ptr, 16'h0000}, 2, acks);
    repeat (n) exp_q.push_back(e);
    host.rd({addr, 1'b1}, n, a);
    check16("read acks", 16'h0007, {13'h0000, a, acks[1:0]});
  endtask : reg_rd

  // Read word watcher: oldest note against each word seen
  always @(posedge core_clk_i) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        // No note left, so any word seen here is a mismatch
        check16("unexpected read", ~rd_word, rd_word);
      end else begin
        check16("read word", exp_q.pop_front(), rd_word);
      end
    end
  end

  // Abort pulses counted so each config write shows exactly one
  always @(posedge core_clk_i) begin
    if (!rst_i && abort === 1'b1) begin
      aborts <= aborts + 1;
    end
  end

  task automatic results();
    $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] w, c, e;
    logic [15:0] thr [2];
    logic [3:0] acks;
    int n;
    repeat (2) @(negedge core_clk_i);
    rst_i = 1'b0;
    w = 16'(rnd());
    flags = w[3:0];
    addr = w[14:8];
    check16("config_o", 16'hC810, cfg);
    check16("light_result_o", 16'h0000, res);
    check16("sda_oe_o", 16'h0000, {15'h0000, sda_oe});
    reg_rd(8'h00, 16'h0000, 1);
    reg_rd(8'h01, cfg_rd(16'hC810), 1);
    reg_rd(8'h7E, 16'h1234, 1);
    reg_rd(8'h7F, 16'h5678, 1);
    // Thresholds written and read back, both bytes
    for (int i = 0; i < 2; i++) begin
      thr[i] = 16'(rnd());
      reg_wr(8'h02 + 8'(i), thr[i]);
      reg_rd(8'h02 + 8'(i), thr[i], 1);
    end
    check16("lower_threshold_o", thr[0], lo_thr);
    check16("upper_threshold_o", thr[1], hi_thr);
    // Range codes with and without exponent mask, then a conversion
    for (int i = 0; i < 4; i++) begin
      c = 16'(rnd());
      c[15:12] = ranges[i];
      c[2] = masks[i];
      n = aborts;
      reg_wr(8'h01, c);
      check16("config_o", c, cfg);
      check16("abort pulses", 16'h0001, 16'(aborts - n));
      reg_rd(8'h01, cfg_rd(c), 1);
      w = 16'(rnd());
      conv_res = w;
      conv_done = 1'b1;
      @(negedge core_clk_i);
      conv_done = 1'b0;
      @(negedge core_clk_i);
      check16("light_result_o", w, res);
      e = (c[2] && c[15:12] < 4'hC) ? {4'h0, w[11:0]} : w;
      reg_rd(8'h00, e, 2);
    end
    // Writes to read-only and unmapped places change nothing
    n = aborts;
    for (int i = 0; i < 4; i++) begin
      reg_wr(ptrs[i], 16'(rnd()));
    end
    reg_rd(8'h00, e, 1);
    reg_rd(8'h7E, 16'h1234, 1);
    reg_rd(8'h7F, 16'h5678, 1);
    reg_rd(8'h40, 16'h0000, 1);
    check16("config_o", c, cfg);
    check16("abort pulses", 16'h0000, 16'(aborts - n));
    // Foreign address: no ack and no write
    host.wr({addr ^ 7'h01, 1'b0, 8'h02, ~thr[0]}, 4, acks);
    check16("foreign acks", 16'h0000, {12'h000, acks});
    check16("lower_threshold_o", thr[0], lo_thr);
    reg_rd(8'h03, thr[1], 1);
    repeat (10) @(negedge core_clk_i);
    check16("notes left", 16'h0000, 16'(exp_q.size()));
    results();
  end

  // Watchdog about three times the roughly 13000 cycles the run needs
  initial begin
    repeat (40000) @(posedge core_clk_i);
    n_fail++;
    results();
  end
endmodule : ambient_light_register_map_test
